// file: fss_defines.vh
`ifndef FSS_DEFINES_VH
`define FSS_DEFINES_VH

// facade count and field widths
`define FSS_NUM_FACADES   8
`define FSS_ANGLE_W       9
`define FSS_OPEN_W        8
`define FSS_BRIGHT_W      16
`define FSS_LAT_W         8
`define FSS_LON_W         9
`define FSS_HEIGHT_W      16
`define FSS_POS_W         8

// angle limits in degrees
`define FSS_DEG_FULL      10'h168
`define FSS_DEG_HALF      10'h0b4
`define FSS_OPEN_MIN      8'h01
`define FSS_OPEN_MAX      8'hb4
`define FSS_LAT_MAX       8'sh5a
`define FSS_LAT_MIN       -8'sh5a
`define FSS_LON_MAX       9'sh0b4
`define FSS_LON_MIN       -9'sh0b4

// shading positions for the byte-format object
`define FSS_POS_SHADE     8'h64
`define FSS_POS_OPEN      8'h00

// reset values
`define FSS_RST_THRESH    16'h0000
`define FSS_RST_OPEN      8'hb4

`endif

// file: fss_facade_window.v
`timescale 1ns/1ps
`default_nettype none
`include "fss_defines.vh"

module fss_facade_window (
   input  wire [`FSS_ANGLE_W-1:0] azimuth,
   input  wire [`FSS_ANGLE_W-1:0] orientation,
   input  wire [`FSS_OPEN_W-1:0]  opening,
   output wire                    inWindow
);

   wire [9:0] rawDiff;
   wire [9:0] modDiff;
   wire [9:0] angDist;
   wire [10:0] twiceDist;

   // angle from orientation to sun, folded into 0..359 without a divider
   assign rawDiff = {1'b0, azimuth} + `FSS_DEG_FULL - {1'b0, orientation};
   assign modDiff = (rawDiff >= `FSS_DEG_FULL) ? (rawDiff - `FSS_DEG_FULL) : rawDiff;
   // shortest way round, so 350 and 10 are 20 apart
   assign angDist = (modDiff > `FSS_DEG_HALF) ? (`FSS_DEG_FULL - modDiff) : modDiff;

   // half the opening on each side: compare twice the distance, no rounding loss
   assign twiceDist = {angDist, 1'b0};
   assign inWindow = (twiceDist <= {3'h0, opening});

endmodule
`default_nettype wire

// file: fss_selector.v
// Notes on behaviour
// - Up to eight facades are judged independently, each with its own orientation and opening.
// - Shading may start only while one of the four brightness readings is above the threshold.
// - A select input picks the preset threshold or the last one received from the bus.
// - The sun position comes from the location plus time and date; this block supplies location.
// - With satellite positioning on and delivering, its location replaces the configured one.
// - With satellite positioning off, manual position entry is forced on and used alone.
// - The received-location objects exist only while satellite positioning is on and show it.
// - Latitude is signed -90..+90 and longitude signed -180..+180; wider values saturate.
// - Azimuth is counted from north to the sun centre, elevation up from the horizon.
// - A facade is shaded only while the azimuth lies inside its opening region.
// - The opening is the configured value until an external one arrives, which then wins.
// - An opening of 180 shades whenever sun reaches the facade, 1 only when nearly square on.
// - Each facade output is a one-bit object or a one-byte position, chosen per facade.
`timescale 1ns/1ps
`default_nettype none
`include "fss_defines.vh"

module fss_selector #(
   parameter NUM_FACADES = `FSS_NUM_FACADES
) (
   input  wire                                  sys_clk,
   input  wire                                  rstn,
   input  wire                                  clkEn,
   input  wire                                  evalTick,
   input  wire [`FSS_ANGLE_W-1:0]               sunAzimuth,
   input  wire signed [`FSS_ANGLE_W-1:0]        sunElevation,
   input  wire [4*`FSS_BRIGHT_W-1:0]            brightness,
   input  wire                                  threshFromBus,
   input  wire [`FSS_BRIGHT_W-1:0]              threshPreset,
   input  wire [`FSS_BRIGHT_W-1:0]              threshBusValue,
   input  wire                                  threshBusWrite,
   input  wire                                  gnssEnable,
   input  wire                                  gnssValid,
   input  wire signed [`FSS_LAT_W-1:0]          gnssLatitude,
   input  wire signed [`FSS_LON_W-1:0]          gnssLongitude,
   input  wire signed [`FSS_HEIGHT_W-1:0]       gnssHeight,
   input  wire signed [`FSS_LAT_W-1:0]          cfgLatitude,
   input  wire signed [`FSS_LON_W-1:0]          cfgLongitude,
   input  wire signed [`FSS_HEIGHT_W-1:0]       cfgHeight,
   input  wire [NUM_FACADES*`FSS_ANGLE_W-1:0]   facadeOrient,
   input  wire [NUM_FACADES*`FSS_OPEN_W-1:0]    facadeOpenCfg,
   input  wire [`FSS_OPEN_W-1:0]                openBusValue,
   input  wire [NUM_FACADES-1:0]                openBusWrite,
   input  wire [NUM_FACADES-1:0]                fmtByte,
   output wire                                  manualPosForced,
   output reg  signed [`FSS_LAT_W-1:0]          calcLatitude_q,
   output reg  signed [`FSS_LON_W-1:0]          calcLongitude_q,
   output reg  signed [`FSS_HEIGHT_W-1:0]       calcHeight_q,
   output wire                                  gnssObjActive,
   output reg  signed [`FSS_LAT_W-1:0]          gnssObjLatitude_q,
   output reg  signed [`FSS_LON_W-1:0]          gnssObjLongitude_q,
   output reg  signed [`FSS_HEIGHT_W-1:0]       gnssObjHeight_q,
   output reg                                   brightOk_q,
   output reg  [NUM_FACADES-1:0]                shadeBit_q,
   output reg  [NUM_FACADES*`FSS_POS_W-1:0]     shadeByte_q,
   output reg  [NUM_FACADES-1:0]                shadeSend_q
);

   ////////////////////////////////////////////////////////////////////////////
   // saturation helpers for the coordinate ranges
   function signed [`FSS_LAT_W-1:0] clampLat;
      input signed [`FSS_LAT_W-1:0] v;
      begin
         if (v > `FSS_LAT_MAX)
            clampLat = `FSS_LAT_MAX;
         else if (v < `FSS_LAT_MIN)
            clampLat = `FSS_LAT_MIN;
         else
            clampLat = v;
      end
   endfunction

   function signed [`FSS_LON_W-1:0] clampLon;
      input signed [`FSS_LON_W-1:0] v;
      begin
         if (v > `FSS_LON_MAX)
            clampLon = `FSS_LON_MAX;
         else if (v < `FSS_LON_MIN)
            clampLon = `FSS_LON_MIN;
         else
            clampLon = v;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // reset release through two flops; clkEn does not gate it so reset always ends
   reg rstSync1_q;
   reg rstSync2_q;
   wire rstLocal_n;

   always @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rstSync1_q <= 1'b0;
         rstSync2_q <= 1'b0;
      end else begin
         rstSync1_q <= 1'b1;
         rstSync2_q <= rstSync1_q;
      end
   end
   assign rstLocal_n = rstSync2_q;

   ////////////////////////////////////////////////////////////////////////////
   // brightness threshold source and sensor comparison
   reg  [`FSS_BRIGHT_W-1:0] threshBus_q;
   wire [`FSS_BRIGHT_W-1:0] threshSel;
   wire [3:0]               sensorAbove;

   // bus threshold is held until the next bus write
   always @(posedge sys_clk or negedge rstLocal_n) begin
      if (!rstLocal_n)
         threshBus_q <= `FSS_RST_THRESH;
      else if (clkEn && threshBusWrite)
         threshBus_q <= threshBusValue;
   end

   assign threshSel = threshFromBus ? threshBus_q : threshPreset;

   genvar s;
   generate
      for (s = 0; s < 4; s = s + 1) begin : gSensor
         // strictly above: a reading equal to the threshold does not start shading
         assign sensorAbove[s] =
            (brightness[s*`FSS_BRIGHT_W +: `FSS_BRIGHT_W] > threshSel);
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // location source for the sun calculation
   wire useGnss;

   assign manualPosForced = ~gnssEnable;
   assign useGnss         = gnssEnable & gnssValid;
   assign gnssObjActive   = gnssEnable;

   // the calculator sees a steady location; configured values fill any gnss gap
   always @(posedge sys_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         calcLatitude_q  <= {`FSS_LAT_W{1'b0}};
         calcLongitude_q <= {`FSS_LON_W{1'b0}};
         calcHeight_q    <= {`FSS_HEIGHT_W{1'b0}};
      end else if (clkEn) begin
         if (useGnss) begin
            calcLatitude_q  <= clampLat(gnssLatitude);
            calcLongitude_q <= clampLon(gnssLongitude);
            calcHeight_q    <= gnssHeight;
         end else begin
            calcLatitude_q  <= clampLat(cfgLatitude);
            calcLongitude_q <= clampLon(cfgLongitude);
            calcHeight_q    <= cfgHeight;
         end
      end
   end

   // received-location objects: last fix while enabled, zero when disabled
   always @(posedge sys_clk or negedge rstLocal_n) begin
      if (!rstLocal_n) begin
         gnssObjLatitude_q  <= {`FSS_LAT_W{1'b0}};
         gnssObjLongitude_q <= {`FSS_LON_W{1'b0}};
         gnssObjHeight_q    <= {`FSS_HEIGHT_W{1'b0}};
      end else if (clkEn) begin
         if (!gnssEnable) begin
            gnssObjLatitude_q  <= {`FSS_LAT_W{1'b0}};
            gnssObjLongitude_q <= {`FSS_LON_W{1'b0}};
            gnssObjHeight_q    <= {`FSS_HEIGHT_W{1'b0}};
         end else if (gnssValid) begin
            gnssObjLatitude_q  <= clampLat(gnssLatitude);
            gnssObjLongitude_q <= clampLon(gnssLongitude);
            gnssObjHeight_q    <= gnssHeight;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // overall shading permission, sampled on the evaluation tick
   wire sunUp;

   // elevation counted up from the horizon: zero or below means no direct sun
   assign sunUp = (sunElevation > $signed({`FSS_ANGLE_W{1'b0}}));

   always @(posedge sys_clk or negedge rstLocal_n) begin
      if (!rstLocal_n)
         brightOk_q <= 1'b0;
      else if (clkEn && evalTick)
         brightOk_q <= (|sensorAbove) & sunUp;
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-facade opening, window test and output objects
   genvar f;
   generate
      for (f = 0; f < NUM_FACADES; f = f + 1) begin : gFacade
         reg                     extValid_q;
         reg  [`FSS_OPEN_W-1:0]  extOpen_q;
         reg                     shade_q;
         wire [`FSS_OPEN_W-1:0]  openRaw;
         wire [`FSS_OPEN_W-1:0]  openUse;
         wire                    inWindow;
         wire                    shadeNow;

         // an external opening sticks until reset; later writes replace it
         always @(posedge sys_clk or negedge rstLocal_n) begin
            if (!rstLocal_n) begin
               extValid_q <= 1'b0;
               extOpen_q  <= `FSS_RST_OPEN;
            end else if (clkEn && openBusWrite[f]) begin
               extValid_q <= 1'b1;
               extOpen_q  <= openBusValue;
            end
         end

         assign openRaw = extValid_q ? extOpen_q
                                     : facadeOpenCfg[f*`FSS_OPEN_W +: `FSS_OPEN_W];
         // keep the opening in 1..180 so 0 cannot disable and >180 cannot overlap
         assign openUse = (openRaw < `FSS_OPEN_MIN) ? `FSS_OPEN_MIN :
                          (openRaw > `FSS_OPEN_MAX) ? `FSS_OPEN_MAX : openRaw;

         fss_facade_window uWindow (
            .azimuth     (sunAzimuth),
            .orientation (facadeOrient[f*`FSS_ANGLE_W +: `FSS_ANGLE_W]),
            .opening     (openUse),
            .inWindow    (inWindow)
         );

         assign shadeNow = (|sensorAbove) & sunUp & inWindow;

         // decision and object formats updated together on the tick
         always @(posedge sys_clk or negedge rstLocal_n) begin
            if (!rstLocal_n) begin
               shade_q                                 <= 1'b0;
               shadeBit_q[f]                           <= 1'b0;
               shadeByte_q[f*`FSS_POS_W +: `FSS_POS_W] <= `FSS_POS_OPEN;
               shadeSend_q[f]                          <= 1'b0;
            end else if (clkEn) begin
               shadeSend_q[f] <= 1'b0;
               if (evalTick) begin
                  shade_q        <= shadeNow;
                  // a telegram only on a change, to spare the actuators
                  shadeSend_q[f] <= (shadeNow != shade_q);
                  shadeBit_q[f]  <= shadeNow & ~fmtByte[f];
                  shadeByte_q[f*`FSS_POS_W +: `FSS_POS_W] <=
                     (shadeNow & fmtByte[f]) ? `FSS_POS_SHADE : `FSS_POS_OPEN;
               end
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// file: fss_selector_assertions.sv
`timescale 1ns/1ps
`default_nettype none
`include "fss_defines.vh"
module fss_sel_chk #(parameter NUM_FACADES = 8) (
   input wire logic                          sys_clk,
   input wire logic                          rstn,
   input wire logic                          clkEn,
   input wire logic                          evalTick,
   input wire logic                          gnssEnable,
   input wire logic                          gnssValid,
   input wire logic signed [7:0]             gnssLatitude,
   input wire logic signed [15:0]            cfgHeight,
   input wire logic [63:0]                   brightness,
   input wire logic [NUM_FACADES-1:0]        fmtByte,
   input wire logic                          manualPosForced,
   input wire logic                          gnssObjActive,
   input wire logic signed [7:0]             calcLatitude_q,
   input wire logic signed [15:0]            calcHeight_q,
   input wire logic signed [7:0]             gnssObjLatitude_q,
   input wire logic                          brightOk_q,
   input wire logic [NUM_FACADES-1:0]        shadeBit_q,
   input wire logic [NUM_FACADES*8-1:0]      shadeByte_q,
   input wire logic [NUM_FACADES-1:0]        shadeSend_q
);
   logic [1:0] live_q;
   wire        take;
   ////////////////////////////////////////////////////////////////
   // inputs only count once the two-flop reset release is over
   always @(posedge sys_clk or negedge rstn)
      if (!rstn)
         live_q <= 2'h0;
      else
         live_q <= {live_q[0], 1'b1};
   assign take = live_q[1] && clkEn;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   ////////////////////////////////////////////////////////////////
   property p_forced; manualPosForced == !gnssEnable; endproperty
   a_forced: assert property (p_forced) else $error("manual flag wrong");
   property p_objon; gnssObjActive == gnssEnable; endproperty
   a_objon: assert property (p_objon) else $error("object flag wrong");
   property p_objz; take && !gnssEnable |=> gnssObjLatitude_q == 8'h00; endproperty
   a_objz: assert property (p_objz) else $error("object not cleared");
   property p_gnss;
      take && gnssEnable && gnssValid && gnssLatitude >= -8'sd90 && gnssLatitude <= 8'sd90
      |=> calcLatitude_q == $past(gnssLatitude);
   endproperty
   a_gnss: assert property (p_gnss) else $error("fix not used");
   property p_cfg; take && !gnssEnable |=> calcHeight_q == $past(cfgHeight); endproperty
   a_cfg: assert property (p_cfg) else $error("config height not used");
   property p_dark; take && evalTick && brightness == 64'h0 |=> !brightOk_q; endproperty
   a_dark: assert property (p_dark) else $error("dark yet bright");
   property p_need; |shadeBit_q |-> brightOk_q; endproperty
   a_need: assert property (p_need) else $error("shade without light");
   property p_fmt; take && evalTick && fmtByte == '0 |=> shadeByte_q == '0; endproperty
   a_fmt: assert property (p_fmt) else $error("byte out in bit format");
   property p_send; (shadeBit_q & ~$past(shadeBit_q) & ~shadeSend_q) == '0; endproperty
   a_send: assert property (p_send) else $error("rise without send");
endmodule
bind fss_selector fss_sel_chk #(.NUM_FACADES(NUM_FACADES)) u_fss_sel_chk (
   .sys_clk           (sys_clk),
   .rstn              (rstn),
   .clkEn             (clkEn),
   .evalTick          (evalTick),
   .gnssEnable        (gnssEnable),
   .gnssValid         (gnssValid),
   .gnssLatitude      (gnssLatitude),
   .cfgHeight         (cfgHeight),
   .brightness        (brightness),
   .fmtByte           (fmtByte),
   .manualPosForced   (manualPosForced),
   .gnssObjActive     (gnssObjActive),
   .calcLatitude_q    (calcLatitude_q),
   .calcHeight_q      (calcHeight_q),
   .gnssObjLatitude_q (gnssObjLatitude_q),
   .brightOk_q        (brightOk_q),
   .shadeBit_q        (shadeBit_q),
   .shadeByte_q       (shadeByte_q),
   .shadeSend_q       (shadeSend_q)
);
`default_nettype wire

// file: fss_blind_actuator.sv
`timescale 1ns/1ps
`default_nettype none
module fss_blind_actuator (
   input wire logic        sys_clk,
   input wire logic [7:0]  shadeSend,
   input wire logic [7:0]  shadeBit,
   input wire logic [63:0] shadeByte,
   input wire logic [7:0]  fmtByte,
   output var logic [7:0]  lowered = 8'h00
);
   // acts only on a telegram; matching object format per facade
   always @(posedge sys_clk)
      for (int f = 0; f < 8; f++)
         if (shadeSend[f])
            lowered[f] <= fmtByte[f] ? shadeByte[8*f+:8] == 8'h64 : shadeBit[f];
endmodule
`default_nettype wire

// file: facade_shading_selector_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin errCount++; \
   $display("ERROR %0t: got %h exp %h", $time, a, b); end end
module facade_shading_selector_tb_top;
   logic sys_clk = 0, rstn = 0, clkEn = 0, evalTick = 0, threshFromBus = 0, threshBusWrite = 0;
   logic gnssEnable = 0, gnssValid = 0;
   logic [8:0] sunAzimuth = 0;
   logic signed [8:0] sunElevation = 9'h01e, gnssLongitude = 9'h138, cfgLongitude = 9'h00d;
   logic [63:0] brightness = 0;
   logic [15:0] threshPreset = 16'h1000, threshBusValue = 16'h3000;
   logic signed [7:0] gnssLatitude = 8'h64, cfgLatitude = 8'h34;
   logic signed [15:0] gnssHeight = 16'h0100, cfgHeight = 16'h0022;
   logic [71:0] facadeOrient = {9'h167, 9'h0c8, 9'h02d, 9'h10e, 9'h0b4, 9'h15e, 9'h000, 9'h05a};
   logic [63:0] facadeOpenCfg = {8'h05, 8'h02, 8'h0a, 8'h5a, 8'h14, 8'h28, 8'h01, 8'hb4};
   logic [7:0] openBusValue = 0, openBusWrite = 0, fmtByte = 8'h88, prev = 0;
   wire manualPosForced, gnssObjActive, brightOk_q;
   wire signed [7:0] calcLatitude_q, gnssObjLatitude_q;
   wire signed [8:0] calcLongitude_q, gnssObjLongitude_q;
   wire signed [15:0] calcHeight_q, gnssObjHeight_q;
   wire [7:0] shadeBit_q, shadeSend_q, lowered;
   wire [63:0] shadeByte_q;
   int errCount = 0, nTests = 0, cyc = 0, opE [8];
   // azimuths at the centres and on the edges of the configured windows
   int azList [13] = '{0, 1, 5, 11, 90, 181, 270, 359, 45, 50, 201, 202, 4};
   fss_selector u_fss_selector (.*);
   fss_blind_actuator u_fss_blind_actuator (.sys_clk(sys_clk), .shadeSend(shadeSend_q),
      .shadeBit(shadeBit_q), .shadeByte(shadeByte_q), .fmtByte(fmtByte), .lowered(lowered));
   always #50 sys_clk = ~sys_clk;
   ////////////////////////////////////////////////////////////////
   // shortest distance either way round, so 359 and 1 are close
   function automatic bit inWin(int a, int o, int w);
      int d;
      d = (a - o + 360) % 360;
      if (d > 180)
         d = 360 - d;
      return 2 * d <= w;
   endfunction
   task automatic giveVerdict();
      $display("mismatches %0d, compares %0d", errCount, nTests);
      if (errCount == 0 && nTests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic loc(bit en, bit vl, logic [7:0] la, logic [8:0] lo, logic [7:0] eLa,
                      logic [8:0] eLo, logic [7:0] eOb, logic [8:0] eObLo);
      @(posedge sys_clk);
      gnssEnable <= en;
      gnssValid <= vl;
      gnssLatitude <= la;
      gnssLongitude <= lo;
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK(calcLatitude_q, eLa)
      `CHK(calcLongitude_q, eLo)
      `CHK(gnssObjLatitude_q, eOb)
      `CHK(gnssObjLongitude_q, eObLo)
      `CHK(gnssObjHeight_q, en ? gnssHeight : 16'sh0000)
      `CHK(manualPosForced, !en)
      `CHK(gnssObjActive, en)
      `CHK(calcHeight_q, en && vl ? gnssHeight : cfgHeight)
      // end on an edge so the caller's next inputs change at a rising edge
      @(posedge sys_clk);
   endtask
   task automatic tick(int a, bit lit);
      logic [7:0] sh;
      for (int f = 0; f < 8; f++)
         sh[f] = lit && inWin(a, facadeOrient[9*f+:9], opE[f]);
      @(posedge sys_clk);
      sunAzimuth <= a[8:0];
      evalTick <= 1;
      @(posedge sys_clk);
      evalTick <= 0;
      #1;
      `CHK(brightOk_q, lit)
      `CHK(shadeBit_q, sh & ~fmtByte)
      `CHK(shadeSend_q, sh ^ prev)
      for (int f = 0; f < 8; f++)
         `CHK(shadeByte_q[8*f+:8], sh[f] & fmtByte[f] ? 8'h64 : 8'h00)
      @(posedge sys_clk);
      #1;
      `CHK(shadeSend_q, 8'h00)
      `CHK(lowered, sh)
      prev = sh;
      @(posedge sys_clk);
   endtask
   // a stuck run ends as a failure
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         errCount++;
         giveVerdict();
      end
   end
   ////////////////////////////////////////////////////////////////
   initial begin
      for (int f = 0; f < 8; f++)
         opE[f] = facadeOpenCfg[8*f+:8];
      repeat (12) @(posedge sys_clk);
      rstn <= 1;
      clkEn <= 1;
      repeat (3) @(posedge sys_clk);
      loc(0, 0, 8'h64, 9'h138, 8'h34, 9'h00d, 8'h00, 9'h000);
      loc(1, 1, 8'h64, 9'h138, 8'h5a, 9'h14c, 8'h5a, 9'h14c);
      loc(1, 0, 8'h9c, 9'h0c8, 8'h34, 9'h00d, 8'h5a, 9'h14c);
      loc(1, 1, 8'h9c, 9'h0c8, 8'ha6, 9'h0b4, 8'ha6, 9'h0b4);
      brightness <= 64'h2000_0000_0000_0000;
      tick(180, 1);
      threshFromBus <= 1;
      threshBusWrite <= 1;
      @(posedge sys_clk);
      threshBusWrite <= 0;
      tick(180, 0);
      brightness <= 64'h3000_0000_0000_0000;
      tick(180, 0);
      brightness <= 64'h3001_0000_0000_0000;
      tick(180, 1);
      sunElevation <= 9'h000;
      tick(180, 0);
      sunElevation <= 9'h01e;
      foreach (azList[i])
         tick(azList[i], 1);
      for (int i = 0; i < 13; i++)
         tick(i * 29 % 360, 1);
      openBusValue <= 8'hff;
      openBusWrite <= 8'h22;
      @(posedge sys_clk);
      openBusValue <= 8'h00;
      openBusWrite <= 8'h40;
      @(posedge sys_clk);
      openBusWrite <= 8'h00;
      opE[1] = 180;
      opE[5] = 180;
      opE[6] = 1;
      tick(90, 1);
      tick(201, 1);
      brightness <= 64'h0;
      tick(90, 0);
      // format switched to bit objects only while no facade is shaded, so no rise goes unsent
      fmtByte <= 8'h00;
      brightness <= 64'h0000_0000_0000_4000;
      tick(90, 1);
      fmtByte <= 8'hff;
      brightness <= 64'h0000_0000_4000_0000;
      tick(90, 1);
      brightness <= 64'h0000_4000_0000_0000;
      tick(270, 1);
      // a tick with the enable low must leave brightOk_q and the byte objects frozen
      clkEn <= 0;
      brightness <= 64'h0;
      evalTick <= 1;
      @(posedge sys_clk);
      evalTick <= 0;
      repeat (2) @(posedge sys_clk);
      #1;
      `CHK(brightOk_q, 1'b1)
      `CHK(shadeByte_q, 64'h0000_0064_0000_6400)
      @(posedge sys_clk);
      clkEn <= 1;
      @(posedge sys_clk);
      giveVerdict();
   end
endmodule
`default_nettype wire
